// file: testbench/mbpc_mem_model.sv
`timescale 1ns/1ps
module mbpc_mem_model
  import mbpc_pkg::*;
#(
  parameter logic [DATA_W-1:0] RD_PAT = 32'h5a3c96e1
)
(
  // Controller pins
  input wire mbpc_pins_type pins_i,
  input wire logic [7:0] wait_i,
  // Device answers
  output logic [DATA_W-1:0] data_o,
  output logic ready_o
);
  logic lk;
  logic [7:0] cnt;
  wire logic sel_io;
  wire logic rd_on;

  // Slow devices sit only on the top three selects
  assign sel_io = ~&pins_i.static_chip_select_n[5:3];
  assign rd_on = pins_i.bus_direction & ~pins_i.mem_output_enable_n;
  // Ready rises once the wait count reaches wait_i and is high off the slow selects; 8'hff is a stuck device
  assign ready_o = (wait_i == 8'hff) ? 1'b0 : (sel_io ? (cnt >= wait_i) : 1'b1);

  // Link-rate clock, standing still outside a slow access
  initial
  begin
    lk = 1'b0;
    cnt = 8'h0;
    #3;
    forever
    begin
      #80;
      lk = sel_io ? ~lk : 1'b0;
    end
  end

  // Wait counter restarts with every slow access
  always @(posedge lk or negedge sel_io)
  begin
    if (!sel_io)
      cnt <= 8'h0;
    else if (cnt != 8'hfe)
      cnt <= cnt + 8'h1;
  end

  // Data only while read-enabled; otherwise a pattern flipping every 10 ns between RD_PAT and its inverse
  initial
  begin
    data_o = ~RD_PAT;
    forever
    begin
      #10;
      data_o = rd_on ? RD_PAT : ~data_o;
    end
  end
endmodule : mbpc_mem_model

// file: testbench/tb_mbpc_memory_bus_pin_control.sv
`timescale 1ns/1ps
module tb_mbpc_memory_bus_pin_control
  import mbpc_pkg::*;
;
  localparam logic [DATA_W-1:0] RD_PAT = 32'h5a3c96e1;
  localparam logic [25:0] ADR = 26'h2abcdef;
  logic sys_clk_i, rst_i, req_valid_i, req_ready_o, done_o, error_o, cfg_error_o;
  logic bus16_i, boot_bank_sync_rom_enable_i, sleep_i, ready_i, act, colx, err, busy;
  logic [1:0] clock_enable_off_i, card_present_i, sync_mem_clock_enable_o;
  logic [N_MCLK-1:0] mem_clock_off_i, sync_mem_clock_out_o;
  logic [DATA_W-1:0] rdata_o, data_in_i;
  logic [7:0] rdy_wait;
  mbpc_req_type req_i;
  mbpc_static_kind_type [N_STATIC-1:0] static_kind_i;
  mbpc_dyn_kind_type [N_DYN-1:0] dyn_kind_i;
  mbpc_pins_type pins_o, p2, pl;
  int miscompares, checks, lat, n;

  // Block under test and the devices on its pins
  mbpc_memory_bus_pin_control mbpc_memory_bus_pin_control_i (
    .sys_clk_i, .rst_i, .req_valid_i, .req_i, .req_ready_o, .done_o, .error_o, .rdata_o,
    .static_kind_i, .dyn_kind_i, .bus16_i, .boot_bank_sync_rom_enable_i, .clock_enable_off_i,
    .mem_clock_off_i, .sleep_i, .cfg_error_o, .pins_o, .data_in_i, .ready_i, .card_present_i,
    .sync_mem_clock_enable_o, .sync_mem_clock_out_o
  );
  mbpc_mem_model #(.RD_PAT(RD_PAT)) mbpc_mem_model_i (
    .pins_i(pins_o), .wait_i(rdy_wait), .data_o(data_in_i), .ready_o(ready_i)
  );

  // 100 MHz clock
  initial
  begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  task automatic conclude();
    if (miscompares == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One access; keeps pins of cycle 2 and of the cycle before the answer
  task automatic acc(input logic w, input mbpc_target_type t, input logic [2:0] b,
                     input logic [25:0] a, input logic [31:0] d, input logic [3:0] be);
    mbpc_req_type r;
    r = '{write: w, target: t, bank: b, addr: a, wdata: d, byte_en: be};
    act = 1'b0;
    colx = 1'b0;
    lat = 0;
    @(posedge sys_clk_i);
    req_valid_i <= 1'b1;
    req_i <= r;
    @(posedge sys_clk_i);
    req_valid_i <= 1'b0;
    // A refusal stands only in the cycle after the take, so look just past that edge
    #1;
    while (lat < 400 && done_o !== 1'b1 && error_o !== 1'b1)
    begin
      pl = pins_o;
      @(posedge sys_clk_i);
      #1;
      lat++;
      if (lat == 2)
        p2 = pins_o;
      act |= pins_o.sync_dyn_row_strobe_n === 1'b0
             && pins_o.dyn_row_strobe_or_sync_select_n[b[1:0]] === 1'b0;
      colx |= pins_o.sync_dyn_col_strobe_n === 1'b0;
    end
    err = error_o;
    busy = ~req_ready_o;
    if (lat >= 400)
    begin
      miscompares++;
      conclude();
    end
    @(posedge sys_clk_i);
  endtask : acc

  // A refused request answers in one cycle and moves no select
  task automatic refused(input mbpc_target_type t, input logic [2:0] b);
    acc(1'b0, t, b, ADR, 32'h0, 4'hf);
    chk({err, busy, 30'(lat)}, 32'h80000000);
    chk({pins_o.static_chip_select_n, pins_o.dyn_row_strobe_or_sync_select_n}, 10'h3ff);
  endtask : refused

  // Rising edges of one memory clock over 16 cycles, sampled settled just before each edge
  task automatic clk_rises(input int k);
    logic prev;
    n = 0;
    prev = sync_mem_clock_out_o[k];
    repeat (16)
    begin
      @(posedge sys_clk_i);
      if (sync_mem_clock_out_o[k] === 1'b1 && prev === 1'b0)
        n++;
      prev = sync_mem_clock_out_o[k];
    end
  endtask : clk_rises

  // Main sequence
  initial
  begin
    miscompares = 0;
    checks = 0;
    rst_i = 1'b1;
    req_valid_i = 1'b0;
    req_i = '0;
    bus16_i = 1'b0;
    boot_bank_sync_rom_enable_i = 1'b0;
    clock_enable_off_i = 2'h0;
    mem_clock_off_i = 3'h0;
    sleep_i = 1'b0;
    card_present_i = 2'h1;
    rdy_wait = 8'h0;
    static_kind_i[0] = SK_ROM;
    static_kind_i[1] = SK_BURST_ROM;
    static_kind_i[2] = SK_SRAM;
    static_kind_i[3] = SK_VLIO;
    static_kind_i[4] = SK_VLIO;
    static_kind_i[5] = SK_ROM;
    dyn_kind_i[0] = DK_FAST_PAGE;
    dyn_kind_i[1] = DK_EXT_OUT;
    dyn_kind_i[2] = DK_SYNC;
    dyn_kind_i[3] = DK_NONE;
    repeat (10) @(posedge sys_clk_i);
    chk(pins_o.static_chip_select_n, 6'h3f);
    chk(sync_mem_clock_enable_o, 2'h0);
    chk(sync_mem_clock_out_o, 3'h0);
    rst_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    chk(cfg_error_o, 1'b0);
    chk(sync_mem_clock_enable_o, 2'h3);
    for (int k = 0; k < N_MCLK; k++)
    begin
      clk_rises(k);
      chk(n, 4);
    end
    // Sleep, then enable-off bits with and without boot from mask ROM
    sleep_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    clk_rises(1);
    chk(n, 0);
    chk(sync_mem_clock_enable_o[1], 1'b0);
    sleep_i <= 1'b0;
    clock_enable_off_i <= 2'h3;
    repeat (3) @(posedge sys_clk_i);
    chk(sync_mem_clock_enable_o, 2'h0);
    boot_bank_sync_rom_enable_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    chk(sync_mem_clock_enable_o, 2'h1);
    mem_clock_off_i <= 3'h7;
    clk_rises(0);
    chk(n, 4);
    clk_rises(2);
    chk(n, 0);
    rst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    chk(sync_mem_clock_enable_o, 2'h1);
    clock_enable_off_i <= 2'h0;
    mem_clock_off_i <= 3'h0;
    boot_bank_sync_rom_enable_i <= 1'b0;
    rst_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    // Static byte write
    acc(1'b1, TG_STATIC, 3'h0, ADR, 32'h12345678, 4'h5);
    chk({busy, 31'(lat)}, {1'b1, 31'(STATIC_WAIT) + 31'h1});
    chk(p2.addr, ADR);
    chk(p2.static_chip_select_n, 6'h3e);
    chk({p2.mem_write_enable_n, p2.bus_direction}, 2'h0);
    chk(p2.dyn_col_strobe_or_byte_mask, 4'ha);
    chk(p2.data_oe, LANES_32);
    chk(p2.data_out, 32'h12345678);
    // Reads on every static bank; ready stuck low where it must be ignored
    for (int b = 0; b < N_STATIC; b++)
    begin
      rdy_wait <= (b == 3 || b == 4) ? 8'h0 : 8'hff;
      acc(1'b0, TG_STATIC, 3'(b), ADR, 32'h0, 4'hf);
      chk(err, 1'b0);
      if (b != 3 && b != 4)
        chk(lat, int'(STATIC_WAIT) + 1);
      chk(p2.static_chip_select_n, 6'(~(6'h1 << b)));
      chk(p2.bus_direction, 1'b1);
      chk(rdata_o, RD_PAT);
    end
    rdy_wait <= 8'h0;
    // Narrow bus
    bus16_i <= 1'b1;
    acc(1'b1, TG_STATIC, 3'h2, ADR, 32'h12345678, 4'hf);
    chk(p2.data_oe, LANES_16);
    acc(1'b0, TG_STATIC, 3'h4, ADR, 32'h0, 4'hf);
    chk(rdata_o, {16'h0, RD_PAT[15:0]});
    static_kind_i[3] <= SK_SYNC_MASK_ROM;
    refused(TG_STATIC, 3'h3);
    bus16_i <= 1'b0;
    acc(1'b0, TG_STATIC, 3'h3, ADR, 32'h0, 4'hf);
    chk(err, 1'b0);
    // Kinds on banks that may not hold them, then absent banks and an empty card slot
    static_kind_i[4] <= SK_SYNC_MASK_ROM;
    static_kind_i[3] <= SK_SRAM;
    static_kind_i[2] <= SK_VLIO;
    repeat (3) @(posedge sys_clk_i);
    chk(cfg_error_o, 1'b1);
    refused(TG_STATIC, 3'h4);
    refused(TG_STATIC, 3'h3);
    refused(TG_STATIC, 3'h2);
    refused(TG_STATIC, 3'h6);
    refused(TG_DYN, 3'h3);
    refused(TG_DYN, 3'h4);
    refused(TG_CARD, 3'h1);
    static_kind_i[2] <= SK_SRAM;
    static_kind_i[3] <= SK_VLIO;
    static_kind_i[4] <= SK_VLIO;
    // Card slot access and a slow device
    acc(1'b0, TG_CARD, 3'h0, ADR, 32'h0, 4'hf);
    chk({err, p2.card_slot_select, p2.card_enable_n}, 3'h0);
    chk(p2.addr, ADR);
    rdy_wait <= 8'h3;
    acc(1'b0, TG_STATIC, 3'h3, ADR, 32'h0, 4'hf);
    chk(lat > 32 && lat < 72, 1'b1);
    rdy_wait <= 8'h0;
    // Dynamic banks
    for (int b = 0; b < 2; b++)
    begin
      acc(1'b0, TG_DYN, 3'(b), ADR, 32'h0, 4'hf);
      chk(p2.dyn_row_strobe_or_sync_select_n, 4'(~(4'h1 << b)));
      chk(p2.addr[24:10], ADR[25:11]);
      chk(pl.addr[24:10], {5'h0, ADR[10:1]});
      chk(pl.dyn_col_strobe_or_byte_mask, 4'h0);
      chk(rdata_o, RD_PAT);
    end
    acc(1'b1, TG_DYN, 3'h1, ADR, 32'h0, 4'h6);
    chk({pl.mem_write_enable_n, pl.dyn_col_strobe_or_byte_mask}, 5'h09);
    acc(1'b0, TG_DYN, 3'h2, ADR, 32'h0, 4'hf);
    chk({err, act, colx}, 3'h3);
    conclude();
  end
endmodule : tb_mbpc_memory_bus_pin_control

// file: verilog/mbpc_memory_bus_pin_control.sv
`timescale 1ns/1ps
module mbpc_memory_bus_pin_control
  import mbpc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Access request and answer
  input wire logic req_valid_i,
  input wire mbpc_req_type req_i,
  output logic req_ready_o,
  output logic done_o,
  output logic error_o,
  output logic [DATA_W-1:0] rdata_o,
  // Configuration and power control
  input wire mbpc_static_kind_type [N_STATIC-1:0] static_kind_i,
  input wire mbpc_dyn_kind_type [N_DYN-1:0] dyn_kind_i,
  input wire logic bus16_i,
  input wire logic boot_bank_sync_rom_enable_i,
  input wire logic [1:0] clock_enable_off_i,
  input wire logic [N_MCLK-1:0] mem_clock_off_i,
  input wire logic sleep_i,
  output logic cfg_error_o,
  // External pins
  output mbpc_pins_type pins_o,
  input wire logic [DATA_W-1:0] data_in_i,
  input wire logic ready_i,
  input wire logic [1:0] card_present_i,
  output logic [1:0] sync_mem_clock_enable_o,
  output logic [N_MCLK-1:0] sync_mem_clock_out_o
);

  localparam int SYNC_W = DATA_W + 3;

  mbpc_state_type state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  mbpc_req_type req_q, req_d;
  mbpc_pins_type pins_q, pins_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic done_q, done_d;
  logic error_q, error_d;
  logic cfg_error_q;
  logic [1:0] div_q;
  logic [1:0] cke_q;
  logic [SYNC_W-1:0] meta_q, sync_q;

  // Static bank legality per memory kind and bank position
  function automatic logic kind_legal(mbpc_static_kind_type kind, logic [2:0] bank,
                                      logic narrow);
    logic ok;
    ok = 1'b0;
    unique case (kind)
      SK_ROM, SK_BURST_ROM: ok = 1'b1;
      SK_SRAM: ok = (bank <= SRAM_TOP_BANK);
      SK_VLIO: ok = (bank >= VLIO_LOW_BANK);
      SK_SYNC_MASK_ROM: ok = (bank <= SYNC_MASK_ROM_TOP_BANK) && !narrow;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : kind_legal

  // Row or column word placed on the multiplexed dynamic address lines
  function automatic logic [ADDR_W-1:0] dyn_addr(logic [ADDR_W-1:0] a, logic col);
    logic [DYN_ADDR_W-1:0] part;
    part = col ? DYN_ADDR_W'(a[COL_LSB +: COL_W]) : a[ROW_LSB +: DYN_ADDR_W];
    return ADDR_W'(part) << DYN_ADDR_LSB;
  endfunction : dyn_addr

  // Pin inputs pass two flops; only the second stage is read
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= {ready_i, card_present_i, data_in_i};
      sync_q <= meta_q;
    end
  end

  wire ready_s = sync_q[DATA_W + 2];
  wire [1:0] present_s = sync_q[DATA_W +: 2];
  wire [DATA_W-1:0] din_s = sync_q[DATA_W-1:0];

  // Lane selection for the configured bus width
  wire [DATA_W-1:0] lane_mask = bus16_i ? LANES_16 : LANES_32;
  wire [3:0] lane_bytes = bus16_i ? BYTES_16 : BYTES_32;

  // Request decode
  wire [2:0] rbank = req_i.bank;
  wire static_in_range = rbank < STATIC_BANKS;
  wire static_ok = static_in_range && kind_legal(static_kind_i[rbank[2:0]], rbank, bus16_i);
  wire dyn_ok = (rbank < DYN_BANKS) && (dyn_kind_i[rbank[1:0]] != DK_NONE);
  wire card_ok = (rbank < CARD_SLOTS) && present_s[rbank[0]];
  wire req_ok = (req_i.target == TG_STATIC && static_ok) ||
                (req_i.target == TG_DYN && dyn_ok) ||
                (req_i.target == TG_CARD && card_ok);
  wire req_sync_dyn = dyn_kind_i[rbank[1:0]] == DK_SYNC;
  wire [3:0] req_bytes = req_i.byte_en & lane_bytes;
  wire [3:0] cur_bytes = req_q.byte_en & lane_bytes;
  wire [N_DYN-1:0] req_dyn_sel_n = ~(N_DYN'(1) << rbank[1:0]);
  wire [N_DYN-1:0] cur_dyn_sel_n = ~(N_DYN'(1) << req_q.bank[1:0]);
  wire [N_STATIC-1:0] req_cs_n = ~(N_STATIC'(1) << rbank);

  // Ready pacing applies only to ready-paced I/O on the upper selects
  wire cur_vlio = (req_q.target == TG_STATIC) && (req_q.bank < STATIC_BANKS) &&
                  (req_q.bank >= VLIO_LOW_BANK) &&
                  (static_kind_i[req_q.bank] == SK_VLIO);
  wire mclk_tick = div_q == DIV_LAST;

  // Configuration check over all static banks
  logic [N_STATIC-1:0] bank_bad;
  for (genvar g = 0; g < N_STATIC; g++)
  begin : g_check
    assign bank_bad[g] = !kind_legal(static_kind_i[g], 3'(g), bus16_i);
  end

  // Access sequencer
  always_comb
  begin
    logic finish;
    finish = 1'b0;
    state_d = state_q;
    cnt_d = cnt_q;
    req_d = req_q;
    pins_d = pins_q;
    rdata_d = rdata_q;
    done_d = 1'b0;
    error_d = 1'b0;
    unique case (state_q)
      ST_IDLE:
      begin
        if (req_valid_i && !req_ok)
          error_d = 1'b1;
        else if (req_valid_i)
        begin
          req_d = req_i;
          pins_d.bus_direction = !req_i.write;
          pins_d.data_out = req_i.wdata & lane_mask;
          if (req_i.target == TG_DYN && req_sync_dyn)
            state_d = ST_SD_ACT;
          else if (req_i.target == TG_DYN)
          begin
            pins_d.addr = dyn_addr(req_i.addr, 1'b0);
            pins_d.dyn_row_strobe_or_sync_select_n = req_dyn_sel_n;
            cnt_d = ROW_WAIT;
            state_d = ST_ROW;
          end
          else
          begin
            pins_d.addr = req_i.addr;
            pins_d.mem_output_enable_n = req_i.write;
            pins_d.mem_write_enable_n = !req_i.write;
            pins_d.data_oe = req_i.write ? lane_mask : '0;
            // Byte writes qualify the shared write enable per lane
            pins_d.dyn_col_strobe_or_byte_mask = req_i.write ? ~req_bytes : '1;
            if (req_i.target == TG_CARD)
            begin
              pins_d.card_slot_select = rbank[0];
              pins_d.card_enable_n = 1'b0;
            end
            else
              pins_d.static_chip_select_n = req_cs_n;
            cnt_d = STATIC_WAIT;
            state_d = ST_STATIC;
          end
        end
      end
      ST_STATIC:
        if (cnt_q != '0)
          cnt_d = cnt_q - 4'h1;
        else if (cur_vlio)
          state_d = ST_READY;
        else
          finish = 1'b1;
      // Stretch the data phase until the device reports ready
      ST_READY: finish = ready_s;
      ST_ROW:
      begin
        if (cnt_q != '0)
          cnt_d = cnt_q - 4'h1;
        else
        begin
          pins_d.addr = dyn_addr(req_q.addr, 1'b1);
          pins_d.dyn_col_strobe_or_byte_mask = req_q.write ? ~cur_bytes : ~lane_bytes;
          pins_d.mem_write_enable_n = !req_q.write;
          pins_d.mem_output_enable_n = req_q.write;
          pins_d.data_oe = req_q.write ? lane_mask : '0;
          cnt_d = COL_WAIT;
          state_d = ST_COL;
        end
      end
      ST_COL:
        if (cnt_q != '0)
          cnt_d = cnt_q - 4'h1;
        else
          finish = 1'b1;
      ST_SD_ACT:
      begin
        // Commands change just after a memory clock falls
        if (mclk_tick)
        begin
          pins_d.addr = dyn_addr(req_q.addr, 1'b0);
          pins_d.dyn_row_strobe_or_sync_select_n = cur_dyn_sel_n;
          pins_d.sync_dyn_row_strobe_n = 1'b0;
          state_d = ST_SD_CMD;
        end
      end
      ST_SD_CMD:
      begin
        if (mclk_tick)
        begin
          pins_d.addr = dyn_addr(req_q.addr, 1'b1);
          pins_d.sync_dyn_row_strobe_n = 1'b1;
          pins_d.sync_dyn_col_strobe_n = 1'b0;
          pins_d.mem_write_enable_n = !req_q.write;
          pins_d.dyn_col_strobe_or_byte_mask = req_q.write ? ~cur_bytes : ~lane_bytes;
          pins_d.data_oe = req_q.write ? lane_mask : '0;
          cnt_d = SD_LATENCY;
          state_d = ST_SD_LAT;
        end
      end
      ST_SD_LAT:
      begin
        if (mclk_tick)
        begin
          pins_d.dyn_row_strobe_or_sync_select_n = '1;
          pins_d.sync_dyn_col_strobe_n = 1'b1;
          pins_d.mem_write_enable_n = 1'b1;
          if (cnt_q != '0)
            cnt_d = cnt_q - 4'h1;
          else
            finish = 1'b1;
        end
      end
      ST_DONE: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
    // Completion drops every strobe but keeps the address until the next accepted access
    if (finish)
    begin
      rdata_d = din_s & lane_mask;
      done_d = 1'b1;
      pins_d = PINS_IDLE;
      pins_d.addr = pins_q.addr;
      state_d = ST_DONE;
    end
  end

  // Sequencer registers
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      req_q <= '0;
      pins_q <= PINS_IDLE;
      rdata_q <= '0;
      done_q <= 1'b0;
      error_q <= 1'b0;
      cfg_error_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      req_q <= req_d;
      pins_q <= pins_d;
      rdata_q <= rdata_d;
      done_q <= done_d;
      error_q <= error_d;
      cfg_error_q <= |bank_bad;
    end
  end

  // Memory clock divider, free running so the phase is known after reset
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      div_q <= '0;
    else
      div_q <= div_q + 2'h1;
  end

  // Clock enables come up off; the boot mask-ROM term is added outside the flop
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      cke_q <= '0;
    else
      cke_q <= ~clock_enable_off_i;
  end

  // Boot mask ROM keeps its clock and enable regardless of the off bits
  wire rom_boot = boot_bank_sync_rom_enable_i;
  wire [N_MCLK-1:0] clk_off = {mem_clock_off_i[N_MCLK-1:1], mem_clock_off_i[0] & !rom_boot};
  assign sync_mem_clock_enable_o[0] = rom_boot | cke_q[0];
  assign sync_mem_clock_enable_o[1] = cke_q[1] & !sleep_i;
  assign sync_mem_clock_out_o = {N_MCLK{div_q[1] & !sleep_i}} & ~clk_off;

  // Outputs
  assign req_ready_o = state_q == ST_IDLE;
  assign done_o = done_q;
  assign error_o = error_q;
  assign rdata_o = rdata_q;
  assign cfg_error_o = cfg_error_q;
  assign pins_o = pins_q;

  AST_CKE_SLEEP: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    sleep_i |-> !sync_mem_clock_enable_o[1])
    else $error("sync dynamic clock enable high in sleep");

  AST_CKE_BOOT_ROM: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rom_boot && clock_enable_off_i[0] |-> ##1 sync_mem_clock_enable_o[0] ##1
      sync_mem_clock_enable_o[0])
    else $error("mask ROM clock enable dropped while booting from it");

  AST_CLK_SLEEP: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    sleep_i |-> sync_mem_clock_out_o == '0)
    else $error("memory clock running in sleep");

  AST_CLK_QUARTER: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(div_q[1]) |=> div_q[1] ##1 !div_q[1] ##1 !div_q[1] ##1 div_q[1])
    else $error("memory clock not at quarter rate");

  AST_DIR_WRITE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (|pins_q.data_oe) |-> !pins_q.bus_direction && pins_q.mem_output_enable_n)
    else $error("data driven while direction shows a read");

  AST_NARROW_LANES: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    bus16_i && $stable(bus16_i) |-> pins_q.data_oe[DATA_W-1:16] == '0)
    else $error("upper data lanes driven on a 16-bit bus");

  AST_CS_ONEHOT: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $onehot0(~pins_q.static_chip_select_n))
    else $error("more than one static select asserted");

  AST_READY_BANK: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    state_q == ST_READY |-> req_q.bank >= VLIO_LOW_BANK && req_q.target == TG_STATIC)
    else $error("ready wait on a bank below select 3");

  AST_READY_HOLD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    state_q == ST_READY && !ready_s |=> state_q == ST_READY && !done_q)
    else $error("ready-paced access ended while ready low");

  AST_BYTE_WRITE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    state_q == ST_STATIC && !pins_q.mem_write_enable_n |->
      pins_q.dyn_col_strobe_or_byte_mask == ~cur_bytes)
    else $error("byte strobes do not match write lanes");

  AST_DYN_ROW: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    state_q == ST_ROW |-> pins_q.addr == dyn_addr(req_q.addr, 1'b0) &&
      !pins_q.dyn_row_strobe_or_sync_select_n[req_q.bank[1:0]])
    else $error("dynamic row address or strobe wrong");

  AST_REFUSE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    state_q == ST_IDLE && req_valid_i && !req_ok |=> error_o && state_q == ST_IDLE)
    else $error("illegal access not refused");

endmodule : mbpc_memory_bus_pin_control

// file: verilog/mbpc_pkg.sv
package mbpc_pkg;

  // Clock rate and access times
  localparam int CLK_PERIOD_NS = 10;
  localparam int STATIC_ACCESS_NS = 40;
  localparam int DYN_ROW_NS = 30;
  localparam int DYN_COL_NS = 20;
  localparam logic [3:0] STATIC_WAIT = 4'((STATIC_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] ROW_WAIT = 4'((DYN_ROW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] COL_WAIT = 4'((DYN_COL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] SD_LATENCY = 4'h1;

  // Bus geometry
  localparam int N_DYN = 4;
  localparam int N_STATIC = 6;
  localparam int N_MCLK = 3;
  localparam int ADDR_W = 26;
  localparam int DATA_W = 32;
  localparam int DYN_ADDR_LSB = 10;
  localparam int DYN_ADDR_W = 15;
  localparam int ROW_LSB = 11;
  localparam int COL_LSB = 1;
  localparam int COL_W = 10;
  localparam logic [2:0] SRAM_TOP_BANK = 3'h2;
  localparam logic [2:0] VLIO_LOW_BANK = 3'h3;
  localparam logic [2:0] SYNC_MASK_ROM_TOP_BANK = 3'h3;
  localparam logic [2:0] STATIC_BANKS = 3'h6;
  localparam logic [2:0] DYN_BANKS = 3'h4;
  localparam logic [2:0] CARD_SLOTS = 3'h2;
  localparam logic [31:0] LANES_16 = 32'h0000ffff;
  localparam logic [31:0] LANES_32 = 32'hffffffff;
  localparam logic [3:0] BYTES_16 = 4'h3;
  localparam logic [3:0] BYTES_32 = 4'hf;
  localparam logic [1:0] DIV_LAST = 2'h3;

  typedef enum logic [2:0] {
    SK_ROM = 3'h0,
    SK_BURST_ROM = 3'h1,
    SK_SRAM = 3'h2,
    SK_VLIO = 3'h3,
    SK_SYNC_MASK_ROM = 3'h4
  } mbpc_static_kind_type;

  typedef enum logic [1:0] {
    DK_FAST_PAGE = 2'h0,
    DK_EXT_OUT = 2'h1,
    DK_SYNC = 2'h2,
    DK_NONE = 2'h3
  } mbpc_dyn_kind_type;

  typedef enum logic [1:0] {
    TG_DYN = 2'h0,
    TG_STATIC = 2'h1,
    TG_CARD = 2'h2,
    TG_NONE = 2'h3
  } mbpc_target_type;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_STATIC = 4'h1,
    ST_READY = 4'h2,
    ST_ROW = 4'h3,
    ST_COL = 4'h4,
    ST_SD_ACT = 4'h5,
    ST_SD_CMD = 4'h6,
    ST_SD_LAT = 4'h7,
    ST_DONE = 4'h8
  } mbpc_state_type;

  typedef struct packed {
    logic write;
    mbpc_target_type target;
    logic [2:0] bank;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [3:0] byte_en;
  } mbpc_req_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [N_STATIC-1:0] static_chip_select_n;
    logic mem_output_enable_n;
    logic mem_write_enable_n;
    logic [N_DYN-1:0] dyn_row_strobe_or_sync_select_n;
    logic [3:0] dyn_col_strobe_or_byte_mask;
    logic sync_dyn_row_strobe_n;
    logic sync_dyn_col_strobe_n;
    logic bus_direction;
    logic card_slot_select;
    logic card_enable_n;
    logic [DATA_W-1:0] data_out;
    logic [DATA_W-1:0] data_oe;
  } mbpc_pins_type;

  localparam mbpc_pins_type PINS_IDLE = '{
    addr: '0,
    static_chip_select_n: '1,
    mem_output_enable_n: 1'b1,
    mem_write_enable_n: 1'b1,
    dyn_row_strobe_or_sync_select_n: '1,
    dyn_col_strobe_or_byte_mask: '1,
    sync_dyn_row_strobe_n: 1'b1,
    sync_dyn_col_strobe_n: 1'b1,
    bus_direction: 1'b1,
    card_slot_select: 1'b0,
    card_enable_n: 1'b1,
    data_out: '0,
    data_oe: '0
  };

endpackage : mbpc_pkg
